//--- src/pdp_dma_guard.sv
// DMA engine with proxied privilege checks at its memory endpoint
`timescale 1ns/1ps
module pdp_dma_guard
  import pdp_pkg::*;
#(
  parameter int NSETS = 4,       // Parameter sets
  parameter int MEM_WORDS = 32,  // Endpoint memory words
  parameter int PAGE_WORDS = 8,  // Words per protection page
  parameter int ID_W = 4         // Privilege ID width
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic [ID_W-1:0] cpu_privilege_level_bit_id,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic tr_busy,
  output logic tr_privilege_level_bit,
  output logic [ID_W-1:0] tr_privilege_level_bit_id
);

  // ----------------------------------------------------------------
  // Derived sizes and elaboration checks
  // ----------------------------------------------------------------
  localparam int NPAGES = MEM_WORDS / PAGE_WORDS;
  localparam int AW = $clog2(MEM_WORDS);
  localparam int PW = $clog2(PAGE_WORDS);
  localparam int PGW = $clog2(NPAGES);
  localparam int SIW = $clog2(NSETS);

  // Address map leaves room for 8 sets, 64 words, 16 pages, 16 IDs
  if (NSETS < 2 || NSETS > 8 || MEM_WORDS > 64 || NPAGES < 2 || NPAGES > 16 ||
      (1 << AW) != MEM_WORDS || (1 << PW) != PAGE_WORDS || ID_W > 4) begin : g_bad
    $error("pdp_dma_guard: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] dmem [MEM_WORDS];      // Endpoint memory
  logic [31:0] page_attr [NPAGES];    // Per-page permits
  logic [31:0] set_mem [NSETS*4];     // Parameter set memory
  logic [2:0] irq_st;                 // Sticky events
  logic [2:0] irq_mask;               // Event mask
  logic [31:0] flt_st;                // Fault status
  logic [AW-1:0] flt_addr;            // Faulting word index
  logic last_err;                     // Last transfer refused
  pdp_state_t state;                  // Engine state
  pdp_state_t next_state;             // Engine next state
  logic [AW-1:0] e_src;               // Current source word
  logic [AW-1:0] e_dst;               // Current destination word
  logic [15:0] e_cnt;                 // Words left
  logic [31:0] data_q;                // Word in flight

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc = psel & penable & ~pready;        // Access seen, answer next
  wire commit = psel & penable & pready;      // Write takes effect here
  wire wr_commit = commit & pwrite & ~pslverr;
  wire in_reg = paddr <= PDP_OFS_FEAT && paddr[1:0] == 2'h0;
  wire in_page = paddr[11:6] == PDP_OFS_PAGE[11:6] && int'(paddr[5:2]) < NPAGES;
  wire in_set = paddr[11:7] == PDP_OFS_SET[11:7] && int'(paddr[6:4]) < NSETS;
  wire in_mem = paddr[11:8] == PDP_OFS_MEM[11:8] && int'(paddr[7:2]) < MEM_WORDS;
  wire mapped = in_reg | in_page | in_set | in_mem;
  wire [PGW-1:0] page_sel = paddr[PGW+1:2];
  wire [SIW-1:0] set_idx = paddr[SIW+3:4];
  wire [SIW+1:0] set_sel = {set_idx, paddr[3:2]};
  wire [AW-1:0] mem_sel = paddr[AW+1:2];
  wire cpu_mem_wr = wr_commit & in_mem;

  // Captured writer identity: APB privileged bit is the level
  wire cap_privilege_level_bit = pprot[0] ? PDP_PRIVILEGE_LEVEL_BIT_SUP : PDP_PRIVILEGE_LEVEL_BIT_USER;
  wire [31:0] cap_opt = (32'(cap_privilege_level_bit) << PDP_OPT_PRIVILEGE_LEVEL_BIT) |
                        (32'(cpu_privilege_level_bit_id) << PDP_OPT_ID_LSB);

  // Status and feature words
  // Bit 3 spare, leaves room to widen the two-bit state field to three bits for later states
  wire [31:0] stat_word = {27'h0, last_err, 1'b0, state, tr_busy};
  wire [31:0] feat_word = 32'(PDP_SNOOP) << PDP_FEAT_SNOOP;
  wire [31:0] reg_rd =
    paddr == PDP_OFS_STAT ? stat_word :
    paddr == PDP_OFS_IRQ_ST ? {29'h0, irq_st} :
    paddr == PDP_OFS_IRQ_MSK ? {29'h0, irq_mask} :
    paddr == PDP_OFS_FLT_ST ? flt_st :
    paddr == PDP_OFS_FLT_ADDR ? 32'(flt_addr) :
    paddr == PDP_OFS_FEAT ? feat_word : 32'h0;
  wire [31:0] rd_val = in_mem ? dmem[mem_sel] :
                       in_set ? set_mem[set_sel] :
                       in_page ? page_attr[page_sel] :
                       in_reg ? reg_rd : 32'h0;

  // ----------------------------------------------------------------
  // Endpoint permission checks
  // ----------------------------------------------------------------
  // Level permit and ID admit must both hold
  // Admit bits are indexed by ID, so an ID wider than 4 cannot fit
  function automatic logic pdp_permit(input logic [31:0] attr, input logic privilege_level_bit,
                                      input logic [ID_W-1:0] id, input logic wr);
    logic lvl_ok;
    lvl_ok = privilege_level_bit ? (wr ? attr[PDP_PG_SWR] : attr[PDP_PG_SRD])
                  : (wr ? attr[PDP_PG_UW] : attr[PDP_PG_UR]);
    return lvl_ok & attr[PDP_PG_ID_LSB + int'(id)];
  endfunction

  wire [31:0] src_attr = page_attr[e_src[AW-1:PW]];
  wire [31:0] dst_attr = page_attr[e_dst[AW-1:PW]];
  // Requests carry the captured level and ID, not the engine's own
  wire rd_ok = pdp_permit(src_attr, tr_privilege_level_bit, tr_privilege_level_bit_id, 1'b0);
  wire wr_ok = pdp_permit(dst_attr, tr_privilege_level_bit, tr_privilege_level_bit_id, 1'b1);
  wire rd_refuse = state == PDP_READ && !rd_ok;
  wire wr_refuse = state == PDP_WRITE && !wr_ok;
  wire ev_refuse = rd_refuse | wr_refuse;
  wire ev_done = state == PDP_DONE;
  wire [31:0] dst_word = dmem[e_dst];

  // Start only from idle; a start while busy is dropped
  wire start = wr_commit && paddr == PDP_OFS_CTRL && pwdata[PDP_CTRL_START] &&
               state == PDP_IDLE;
  wire [SIW-1:0] start_set = pwdata[SIW-1:0];
  wire [31:0] start_opt = set_mem[{start_set, PDP_W_OPT}];
  wire [15:0] start_cnt = set_mem[{start_set, PDP_W_CNT}][15:0];
  wire [2:0] ev_vec = {ev_refuse, ev_refuse, ev_done};
  wire [2:0] irq_clr = (wr_commit && paddr == PDP_OFS_IRQ_ST) ? pwdata[2:0] : 3'h0;
  wire [2:0] next_irq_st = (irq_st & ~irq_clr) | ev_vec;

  // ----------------------------------------------------------------
  // Engine sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      PDP_IDLE: begin
        if (start) begin
          next_state = (start_cnt == 16'h0) ? PDP_DONE : PDP_READ;
        end
      end
      // Refused read stops before any write
      PDP_READ: next_state = rd_ok ? PDP_WRITE : PDP_IDLE;
      PDP_WRITE: begin
        if (!wr_ok) begin
          next_state = PDP_IDLE;
        end else begin
          next_state = (e_cnt == 16'h1) ? PDP_DONE : PDP_READ;
        end
      end
      // Entered on the same edge as the last write lands, or straight from idle on a zero count
      PDP_DONE: next_state = PDP_IDLE;
    endcase
  end

  // State and busy flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= PDP_IDLE;
      tr_busy <= 1'b0;
    end else begin
      state <= next_state;
      tr_busy <= next_state != PDP_IDLE;
    end
  end

  // Transfer request: privilege copied from the options word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tr_privilege_level_bit <= PDP_PRIVILEGE_LEVEL_BIT_USER;
      tr_privilege_level_bit_id <= '0;
      e_src <= '0;
      e_dst <= '0;
      e_cnt <= 16'h0;
    end else if (start) begin
      tr_privilege_level_bit <= start_opt[PDP_OPT_PRIVILEGE_LEVEL_BIT];
      tr_privilege_level_bit_id <= start_opt[PDP_OPT_ID_LSB +: ID_W];
      e_src <= set_mem[{start_set, PDP_W_SRC}][AW-1:0];
      e_dst <= set_mem[{start_set, PDP_W_DST}][AW-1:0];
      e_cnt <= start_cnt;
    end else if (state == PDP_WRITE && wr_ok) begin
      e_src <= e_src + 1'b1;
      e_dst <= e_dst + 1'b1;
      e_cnt <= e_cnt - 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // Endpoint memory: engine write wins over a CPU write
  // ----------------------------------------------------------------
  // No reset here: memory contents are software's business
  always_ff @(posedge clk_sys) begin
    if (state == PDP_READ && rd_ok) begin
      data_q <= dmem[e_src];
    end
    if (state == PDP_WRITE && wr_ok) begin
      dmem[e_dst] <= data_q;
    end else if (cpu_mem_wr) begin
      dmem[mem_sel] <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Parameter sets and page attributes
  // ----------------------------------------------------------------
  // Any set write reloads that set's options word; options data ignored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NSETS*4; i++) begin
        set_mem[i] <= 32'h0;
      end
    end else if (wr_commit && in_set) begin
      set_mem[set_sel] <= pwdata;
      set_mem[{set_idx, PDP_W_OPT}] <= cap_opt;
    end
  end

  // Page permits; all-zero page grants nobody anything
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NPAGES; i++) begin
        page_attr[i] <= PDP_RST_PAGE;
      end
    end else if (wr_commit && in_page) begin
      page_attr[page_sel] <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Fault record and interrupt
  // ----------------------------------------------------------------
  // Latest refusal overwrites: software must drain it quickly
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flt_st <= 32'h0;
      flt_addr <= '0;
      last_err <= 1'b0;
    end else if (ev_refuse) begin
      flt_st <= (32'h1 << PDP_FLT_VALID) | (32'(wr_refuse) << PDP_FLT_WR) |
                (32'(tr_privilege_level_bit) << PDP_FLT_PRIVILEGE_LEVEL_BIT) | 32'(tr_privilege_level_bit_id);
      flt_addr <= wr_refuse ? e_dst : e_src;
      last_err <= 1'b1;
    end else if (start) begin
      last_err <= 1'b0;
    end
  end

  // Sticky events: a new event beats a clear in the same cycle
  // Irq follows a mask write one cycle late, never glitches
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_st <= 3'h0;
      irq_mask <= PDP_RST_MASK;
      irq <= 1'b0;
    end else begin
      irq_st <= next_irq_st;
      irq <= |(next_irq_st & irq_mask);
      if (wr_commit && paddr == PDP_OFS_IRQ_MSK) begin
        irq_mask <= pwdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      // Wait state costs a cycle but keeps decode off the ready path
      pready <= acc;
      pslverr <= acc & ~mapped;
      prdata <= (acc && !pwrite) ? rd_val : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Each check carries the rule it guards; all share the one clock

  a_opt_capture: assert property (wr_commit && in_set |=>
    set_mem[{$past(set_idx), PDP_W_OPT}][PDP_OPT_ID_LSB +: ID_W] == $past(cpu_privilege_level_bit_id))
    else $error("options word lost writer ID");
  a_privilege_level_bit_user: assert property (wr_commit && in_set && !pprot[0] |=>
    set_mem[{$past(set_idx), PDP_W_OPT}][PDP_OPT_PRIVILEGE_LEVEL_BIT] == 1'b0)
    else $error("user writer not encoded as zero");
  a_req_carry: assert property (start |=>
    tr_privilege_level_bit == $past(start_opt[PDP_OPT_PRIVILEGE_LEVEL_BIT]) &&
    tr_privilege_level_bit_id == $past(start_opt[PDP_OPT_ID_LSB +: ID_W]) &&
    (state == PDP_READ || state == PDP_DONE))
    else $error("request lost captured privilege");
  a_src_refuse: assert property (state == PDP_READ && !tr_privilege_level_bit &&
    src_attr[PDP_PG_SRD] && !src_attr[PDP_PG_UR] |=> state == PDP_IDLE && irq_st[PDP_IRQ_FLT])
    else $error("user read of supervisor page passed");
  a_dst_refuse: assert property (state == PDP_WRITE && !tr_privilege_level_bit &&
    dst_attr[PDP_PG_SWR] && !dst_attr[PDP_PG_UW] |=> state == PDP_IDLE && flt_st[PDP_FLT_WR])
    else $error("user write to supervisor page passed");
  a_user_admit: assert property (state == PDP_WRITE && !tr_privilege_level_bit &&
    !dst_attr[PDP_PG_ID_LSB + int'(tr_privilege_level_bit_id)] |=> state != PDP_DONE ##1 !$rose(irq_st[0]))
    else $error("unadmitted ID completed");
  // Zero-count sets reach done straight from idle, with no word moved
  a_done_late: assert property ($rose(irq_st[PDP_IRQ_DONE]) |->
    $past(state) == PDP_DONE && $past(e_cnt) == 16'h0 && $past(state, 2) != PDP_READ)
    else $error("completion before final write");
  // A page with no level permit refuses every engine access
  a_noaccess_exc: assert property ((state == PDP_READ && src_attr[3:0] == 4'h0) ||
    (state == PDP_WRITE && dst_attr[3:0] == 4'h0) |=> irq_st[PDP_IRQ_FLT] && state == PDP_IDLE)
    else $error("no-access page gave no exception");
  a_fault_record: assert property (ev_refuse |=>
    flt_st[ID_W-1:0] == $past(tr_privilege_level_bit_id) && flt_st[PDP_FLT_WR] == $past(wr_refuse) &&
    flt_st[PDP_FLT_PRIVILEGE_LEVEL_BIT] == $past(tr_privilege_level_bit) && flt_st[PDP_FLT_VALID])
    else $error("fault record wrong");
  a_refuse_keep: assert property (wr_refuse && !cpu_mem_wr |=>
    dmem[$past(e_dst)] == $past(dst_word) && irq_st[PDP_IRQ_ERR])
    else $error("refused write changed memory");
  // A refusal ends the run at once; nothing is retried
  a_refuse_stop: assert property (ev_refuse |=>
    state == PDP_IDLE && last_err && !tr_busy)
    else $error("refused transfer kept running");
  // Level and ID must not move while words are still being written
  a_write_carry: assert property (state == PDP_WRITE |->
    $stable(tr_privilege_level_bit) && $stable(tr_privilege_level_bit_id))
    else $error("privilege changed during transfer");
  // Completion is posted only from the done state, engine already idle
  a_done_event: assert property (state == PDP_DONE |=>
    irq_st[PDP_IRQ_DONE] && !tr_busy)
    else $error("done state gave no completion event");
  // Bus answer: one wait state, then a single ready pulse
  a_pready_pulse: assert property (acc |=> pready ##1 !pready)
    else $error("ready not a single pulse after one wait");
  a_unmapped_err: assert property (acc && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

endmodule // pdp_dma_guard

//--- include/pdp_pkg.sv
// Constants, register map and types of the proxied DMA protection block
// Behaviour
// - Parameter set write captures writer privilege, ID
// - Privilege level bit zero means user
// - Captured privilege travels with every read, write
// - Supervisor-only source page refuses user reads
// - Supervisor-only destination page refuses user writes
// - User transfer needs user permits and ID
// - Completion interrupt only after final write lands
// - No-access page raises exception on every engine access
// - Fault status records requester and access type
// - No snooping between cache and external memory
package pdp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] PDP_OFS_CTRL = 12'h000;     // Start a transfer
  localparam logic [11:0] PDP_OFS_STAT = 12'h004;     // Engine state
  localparam logic [11:0] PDP_OFS_IRQ_ST = 12'h008;   // Sticky events, W1C
  localparam logic [11:0] PDP_OFS_IRQ_MSK = 12'h00c;  // Event mask
  localparam logic [11:0] PDP_OFS_FLT_ST = 12'h010;   // Fault status
  localparam logic [11:0] PDP_OFS_FLT_ADDR = 12'h014; // Faulting word index
  localparam logic [11:0] PDP_OFS_FEAT = 12'h018;     // Feature bits
  localparam logic [11:0] PDP_OFS_PAGE = 12'h040;     // Page attributes
  localparam logic [11:0] PDP_OFS_SET = 12'h080;      // Parameter sets
  localparam logic [11:0] PDP_OFS_MEM = 12'h100;      // Endpoint memory

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PDP_CTRL_START = 31;   // Start strobe in control word
  localparam int PDP_OPT_PRIVILEGE_LEVEL_BIT = 0;      // Privilege level bit in options word
  localparam int PDP_OPT_ID_LSB = 8;    // Privilege ID field in options word
  localparam int PDP_PG_UR = 0;         // User read permit
  localparam int PDP_PG_UW = 1;         // User write permit
  localparam int PDP_PG_SRD = 2;        // Supervisor read permit
  localparam int PDP_PG_SWR = 3;        // Supervisor write permit
  localparam int PDP_PG_ID_LSB = 16;    // One admit bit per privilege ID
  localparam int PDP_IRQ_DONE = 0;      // Transfer complete
  localparam int PDP_IRQ_ERR = 1;       // Transfer ended in error
  localparam int PDP_IRQ_FLT = 2;       // Protection exception
  localparam int PDP_FLT_PRIVILEGE_LEVEL_BIT = 8;      // Fault: requester privilege
  localparam int PDP_FLT_WR = 9;        // Fault: 1 write, 0 read
  localparam int PDP_FLT_VALID = 16;    // Fault: record valid
  localparam int PDP_FEAT_SNOOP = 0;    // Snooping coherency present

  // Word positions inside a parameter set
  localparam logic [1:0] PDP_W_OPT = 2'h0;
  localparam logic [1:0] PDP_W_SRC = 2'h1;
  localparam logic [1:0] PDP_W_DST = 2'h2;
  localparam logic [1:0] PDP_W_CNT = 2'h3;

  // ----------------------------------------------------------------
  // Values and reset values
  // ----------------------------------------------------------------
  localparam logic PDP_PRIVILEGE_LEVEL_BIT_USER = 1'b0;              // User level
  localparam logic PDP_PRIVILEGE_LEVEL_BIT_SUP = 1'b1;               // Supervisor level
  localparam logic [31:0] PDP_RST_PAGE = 32'hffff000f; // All open at reset
  localparam logic [2:0] PDP_RST_MASK = 3'h0;          // All events masked
  localparam logic PDP_SNOOP = 1'b0;                   // No snooping

  // Transfer engine states
  typedef enum logic [1:0] {
    PDP_IDLE = 2'b00,
    PDP_READ = 2'b01,
    PDP_WRITE = 2'b10,
    PDP_DONE = 2'b11
  } pdp_state_t;

endpackage

//--- verification/pdp_cpu_model.sv
// CPU-side APB master model that programs the DMA block
`timescale 1ns/1ps
module pdp_cpu_model (
  input wire logic clk_sys,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic [2:0] pprot,
  output logic [3:0] cpu_privilege_level_bit_id,
  output logic hung
);
  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    {paddr, psel, penable, pwrite, pwdata, pprot, cpu_privilege_level_bit_id, hung} = '0;
  end

  // One transfer; privilege and ID qualify it like the address does
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic p, input logic [3:0] id,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pprot <= {2'b00, p};
    cpu_privilege_level_bit_id <= id;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    // Bounded wait; a lost answer raises the hang flag
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      hung <= 1'b1;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines carry the inverse so stale values never look live
    paddr <= ~a;
    pwdata <= ~d;
    pprot <= ~{2'b00, p};
    cpu_privilege_level_bit_id <= ~id;
  endtask
endmodule // pdp_cpu_model

//--- verification/pdp_dma_guard_tb_top.sv
// Self-checking testbench of the DMA privilege guard
`timescale 1ns/1ps
module pdp_dma_guard_tb_top
  import pdp_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq, tr_busy, tr_privilege_level_bit, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] pprot;
  logic [3:0] cpu_privilege_level_bit_id, tr_privilege_level_bit_id;
  int bad_count = 0;
  int checked = 0;
  // Refusal table: source page, destination page, privilege, pass, write fault
  logic [31:0] ps [5] = '{32'hffff000c, 32'hffff000f, 32'hfffb000f, 32'h0, 32'hffff000c};
  logic [31:0] pd [5] = '{32'hffff000f, 32'hffff000c, 32'hffff000f, 32'hffff000f, 32'hffff000f};
  logic pv [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic ok [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic fw [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  pdp_dma_guard i_pdp_dma_guard (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pprot(pprot),
    .cpu_privilege_level_bit_id(cpu_privilege_level_bit_id), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tr_busy(tr_busy), .tr_privilege_level_bit(tr_privilege_level_bit), .tr_privilege_level_bit_id(tr_privilege_level_bit_id));
  pdp_cpu_model i_pdp_cpu_model (.clk_sys(clk_sys), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pprot(pprot), .cpu_privilege_level_bit_id(cpu_privilege_level_bit_id), .hung(hung));

  // ----------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Whole-run limit; also cut short by a bus hang
  initial begin
    repeat (50000) begin
      @(posedge clk_sys);
      if (hung === 1'b1) break;
    end
    bad_count++;
    $display("unexpected at %0t: bus or run timeout", $time);
    complete_run();
  end
  task automatic complete_run();
    $display("counts: %0d checked, %0d mismatched", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] x, input string m);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask
  task automatic cmp_pin(input logic g, input logic x, input string m);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, m, g, x);
    end
  endtask
  // Irq is registered, so let two cycles pass before looking
  task automatic chk_irq(input logic x);
    repeat (2) @(negedge clk_sys);
    cmp_pin(irq, x, "irq");
  endtask
  task automatic setw(input logic [11:0] a, input logic [31:0] d, input logic p,
                      input logic [3:0] id);
    logic [31:0] r;
    logic e;
    i_pdp_cpu_model.xfer(a, 1'b1, d, p, id, r, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    setw(a, d, PDP_PRIVILEGE_LEVEL_BIT_SUP, 4'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
    logic [31:0] r;
    logic e;
    i_pdp_cpu_model.xfer(a, 1'b0, 32'h0, PDP_PRIVILEGE_LEVEL_BIT_SUP, 4'h0, r, e);
    cmp_reg(r, x, m);
    cmp_pin(e, 1'b0, "slave error");
  endtask
  function automatic logic [11:0] sa(input logic [1:0] s, input logic [1:0] w);
    return PDP_OFS_SET + {6'h0, s, w, 2'b00};
  endfunction
  function automatic logic [11:0] ma(input logic [4:0] i);
    return PDP_OFS_MEM + {5'h0, i, 2'b00};
  endfunction
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (tr_busy !== v && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (tr_busy !== v) begin
      bad_count++;
      $display("unexpected at %0t: engine stuck", $time);
      complete_run();
    end
  endtask
  // Copy of c words from word 2 (page 0) to word 10 (page 1) in set 0
  task automatic run(input logic p, input logic [3:0] id, input logic [31:0] c);
    setw(sa(2'h0, PDP_W_SRC), 32'h2, p, id);
    setw(sa(2'h0, PDP_W_DST), 32'ha, p, id);
    setw(sa(2'h0, PDP_W_CNT), c, p, id);
    wr(PDP_OFS_IRQ_ST, 32'h7);
    wr(PDP_OFS_CTRL, 32'h80000000);
    wait_busy(1'b1);
    cmp_pin(tr_privilege_level_bit, p, "request privilege");
    cmp_reg({28'h0, tr_privilege_level_bit_id}, {28'h0, id}, "request id");
    wait_busy(1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    rst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(PDP_OFS_PAGE, PDP_RST_PAGE, "page reset");
    rd(PDP_OFS_IRQ_MSK, {29'h0, PDP_RST_MASK}, "mask reset");
    rd(PDP_OFS_FEAT, 32'h0, "no snoop");
    i_pdp_cpu_model.xfer(12'h030, 1'b0, 32'h0, 1'b1, 4'h0, r, e);
    cmp_pin(e, 1'b1, "unmapped error");
    cmp_reg(r, 32'h0, "unmapped data");
    $display("test reset and map done");
    setw(sa(2'h1, PDP_W_SRC), 32'h5, PDP_PRIVILEGE_LEVEL_BIT_USER, 4'h5);
    rd(sa(2'h1, PDP_W_OPT), 32'h00000500, "user capture");
    setw(sa(2'h1, PDP_W_OPT), 32'hffffffff, PDP_PRIVILEGE_LEVEL_BIT_SUP, 4'h3);
    rd(sa(2'h1, PDP_W_OPT), 32'h00000301, "supervisor capture");
    $display("test capture done");
    wr(ma(5'h2), 32'h1234abcd);
    wr(ma(5'ha), 32'h0);
    run(PDP_PRIVILEGE_LEVEL_BIT_USER, 4'h2, 32'h1);
    rd(ma(5'ha), 32'h1234abcd, "copied word");
    rd(PDP_OFS_IRQ_ST, 32'h1, "done event");
    chk_irq(1'b0);
    wr(PDP_OFS_IRQ_MSK, 32'h7);
    chk_irq(1'b1);
    wr(PDP_OFS_IRQ_ST, 32'h1);
    chk_irq(1'b0);
    $display("test transfer and interrupt done");
    for (int k = 0; k < 5; k++) begin
      wr(ma(5'ha), 32'h5a5a0000 + k);
      wr(PDP_OFS_PAGE, ps[k]);
      wr(PDP_OFS_PAGE + 12'h4, pd[k]);
      run(pv[k], 4'h2, 32'h1);
      if (ok[k]) begin
        rd(ma(5'ha), 32'h1234abcd, "permitted copy");
        rd(PDP_OFS_IRQ_ST, 32'h1, "permitted event");
      end else begin
        rd(ma(5'ha), 32'h5a5a0000 + k, "refused copy");
        rd(PDP_OFS_IRQ_ST, 32'h6, "refused event");
        rd(PDP_OFS_FLT_ST, {15'h0, 1'b1, 6'h0, fw[k], pv[k], 8'h02}, "fault");
        rd(PDP_OFS_FLT_ADDR, fw[k] ? 32'ha : 32'h2, "fault index");
      end
      rd(PDP_OFS_STAT, ok[k] ? 32'h0 : 32'h10, "status");
      chk_irq(1'b1);
      wr(PDP_OFS_IRQ_ST, 32'h7);
      chk_irq(1'b0);
      $display("test protection case %0d done", k);
    end
    wr(ma(5'ha), 32'h77);
    run(PDP_PRIVILEGE_LEVEL_BIT_SUP, 4'h1, 32'h0);
    rd(ma(5'ha), 32'h77, "empty copy");
    rd(PDP_OFS_IRQ_ST, 32'h1, "empty done");
    $display("test empty transfer done");
    complete_run();
  end
endmodule // pdp_dma_guard_tb_top
